// file: hdl/iups_sequencer.sv
/*
   Indoor unit protection sequencer: freeze prevention, refrigerant recovery,
   minimum-run guard, drain and overflow supervision, heat run-on, louver gate.
   Assumes an AXI4-Lite master on mclk; sensor and outdoor-unit inputs are
   asynchronous pins and are synchronised here.
*/
// Function
// - Five minutes in timing zone while cooling commands zero-frequency code.
// - Hold zone pauses freeze timer, keeping its count.
// - Release zone clears freeze timer, normal cooling resumes.
// - After freeze zero-frequency, fan runs low until release zone.
// - Freeze state ends at both coils >= 12C or 30 minutes stopped.
// - Idle unit opens expansion valve on cooling recovery request.
// - Four-way variant runs fan about 3.5 minutes in cooling recovery.
// - Heating recovery: open valve, stop fan, close on exchanger temperature.
// - Heating recovery lights warm-up indicator on thermostat-off or fan units.
// - Four-way variant runs fan one minute after heating recovery.
// - First five minutes of operation ignore thermostat-off.
// - Setpoint-caused thermostat-off acts at once.
// - Protective controls override the minimum-run guard.
// - Drain pump runs while cooling.
// - Float trip stops compressor and runs drain pump in any mode.
// - Float tripped two minutes raises overflow check code.
// - Check code stops outdoor units and shows standby everywhere.
// - Stop in heating runs fan low about thirty seconds.
// - Louver swings on request only while fan runs.
// - Exchanger sensor feeds both freeze and recovery decisions.
`timescale 1ns/1ns
module iups_sequencer
#(
   parameter int TICK_CYCLES = iups_pkg::TICK_CYCLES
)
(
   input  wire logic        mclk,              // 250 MHz clock
   input  wire logic        reset,             // Async reset, active high
   input  wire logic [3:0]  s_axi_awaddr,      // Write address
   input  wire logic        s_axi_awvalid,     // Write address valid
   output logic             s_axi_awready,     // Write address ready
   input  wire logic [31:0] s_axi_wdata,       // Write data
   input  wire logic [3:0]  s_axi_wstrb,       // Write byte lanes
   input  wire logic        s_axi_wvalid,      // Write data valid
   output logic             s_axi_wready,      // Write data ready
   output logic [1:0]       s_axi_bresp,       // Write response
   output logic             s_axi_bvalid,      // Write response valid
   input  wire logic        s_axi_bready,      // Write response ready
   input  wire logic [3:0]  s_axi_araddr,      // Read address
   input  wire logic        s_axi_arvalid,     // Read address valid
   output logic             s_axi_arready,     // Read address ready
   output logic [31:0]      s_axi_rdata,       // Read data
   output logic [1:0]       s_axi_rresp,       // Read response
   output logic             s_axi_rvalid,      // Read data valid
   input  wire logic        s_axi_rready,      // Read data ready
   input  wire logic [7:0]  coilTempFirst,     // Coil sensor, signed C
   input  wire logic [7:0]  heatExchangerTemp, // Exchanger sensor, signed C
   input  wire logic        overflowFloatSwitch, // Float tripped, high
   input  wire logic        coolRecoveryReq,   // Outdoor cooling recovery
   input  wire logic        heatRecoveryReq,   // Outdoor heating recovery
   output logic             compressorRun,     // Compressor demand
   output logic             zeroFrequencyCode, // Zero-frequency command
   output logic [1:0]       fanSpeed,          // 0 off, 1 low, 2 set
   output logic             drainPump,         // Drain pump on
   output logic             expansionValve,    // Valve open
   output logic             warmupIndicator,   // Warm-up lamp
   output logic             louverRun,         // Swing louver on
   output logic             checkCode,         // Overflow check code
   output logic             outdoorStop,       // Stop outdoor units
   output logic             standbyIndicator   // Standby on remotes
);

   // ==========================================================
   // Input synchronisers
   // Temperatures are slow; a word caught mid-change settles next clock
   logic [18:0] syncA;
   logic [18:0] syncB;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         syncA <= 19'h00000;
         syncB <= 19'h00000;
      end
      else
      begin
         syncA <= {heatRecoveryReq, coolRecoveryReq, overflowFloatSwitch,
                   heatExchangerTemp, coilTempFirst};
         syncB <= syncA;
      end
   end

   logic signed [7:0] tc1;
   logic signed [7:0] tc2;
   logic              floatOn;
   logic              coolReq;
   logic              heatReq;
   assign tc1     = syncB[7:0];
   assign tc2     = syncB[15:8];
   assign floatOn = syncB[16];
   assign coolReq = syncB[17];
   assign heatReq = syncB[18];

   // ==========================================================
   // Control register
   logic [6:0] ctrl;
   logic       clrCheck;
   logic       run;
   logic [1:0] mode;
   assign run  = ctrl[iups_pkg::CTRL_RUN];
   assign mode = ctrl[iups_pkg::CTRL_MODE_LO +: 2];

   // ==========================================================
   // Tick prescaler
   // common tick
   logic [27:0] prescale;
   logic        tick;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         prescale <= 28'h0000000;
         tick     <= 1'b0;
      end
      else
      begin
         tick     <= (prescale == 28'(TICK_CYCLES - 1));
         prescale <= (prescale == 28'(TICK_CYCLES - 1)) ? 28'h0000000 : prescale + 28'h0000001;
      end
   end

   // ==========================================================
   // Zones and operating conditions
   logic zoneRelease;
   logic zoneTiming;
   logic coolActive;
   logic thOffEff;
   logic idleUnit;
   assign zoneRelease = (tc1 >= iups_pkg::RELEASE_TEMP) && (tc2 >= iups_pkg::RELEASE_TEMP);
   assign zoneTiming  = (tc1 <= iups_pkg::TIMING_TC1) || (tc2 <= iups_pkg::TIMING_TC2);
   assign coolActive  = run && (mode == iups_pkg::MODE_COOL);

   iups_pkg::iups_frz_t frz;
   iups_pkg::iups_hr_t  hr;
   logic [11:0] freezeCnt;
   logic [11:0] stopCnt;
   logic [11:0] runCnt;
   logic [11:0] floatCnt;
   logic [11:0] runOnLeft;
   logic [11:0] coolFanLeft;
   logic [11:0] heatFanLeft;
   logic        prevRun;
   logic        prevHeat;
   logic        prevCoolRec;
   logic        protect;

   assign protect  = (frz == iups_pkg::FRZ_HELD) || floatOn || checkCode;
   assign thOffEff = ctrl[iups_pkg::CTRL_THOFF]
                     && ((runCnt == 12'(iups_pkg::MINRUN_TICKS))
                         || ctrl[iups_pkg::CTRL_SETPT] || protect);
   assign idleUnit = !run || thOffEff || (mode == iups_pkg::MODE_FAN);

   // ==========================================================
   // Freeze prevention
   // hold keeps count, release clears
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         freezeCnt <= 12'h000;
      else if (!coolActive || zoneRelease || frz == iups_pkg::FRZ_HELD)
         freezeCnt <= 12'h000;
      else if (tick && zoneTiming && freezeCnt != 12'(iups_pkg::FREEZE_TICKS))
         freezeCnt <= freezeCnt + 12'h001;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         frz <= iups_pkg::FRZ_NORMAL;
      else
         unique case (frz)
            iups_pkg::FRZ_NORMAL:
               if (freezeCnt == 12'(iups_pkg::FREEZE_TICKS))
                  frz <= iups_pkg::FRZ_HELD;
            iups_pkg::FRZ_HELD:
               if (zoneRelease || stopCnt == 12'(iups_pkg::UNFREEZE_TICKS))
                  frz <= iups_pkg::FRZ_NORMAL;
            default:
               frz <= iups_pkg::FRZ_NORMAL;
         endcase
   end

   // ==========================================================
   // Second timers
   // hold at their limit
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         stopCnt  <= 12'h000;
         runCnt   <= 12'h000;
         floatCnt <= 12'h000;
      end
      else
      begin
         if (run)
            stopCnt <= 12'h000;
         else if (tick && stopCnt != 12'(iups_pkg::UNFREEZE_TICKS))
            stopCnt <= stopCnt + 12'h001;
         if (!run)
            runCnt <= 12'h000;
         else if (tick && runCnt != 12'(iups_pkg::MINRUN_TICKS))
            runCnt <= runCnt + 12'h001;
         if (!floatOn)
            floatCnt <= 12'h000;
         else if (tick && floatCnt != 12'(iups_pkg::FLOAT_TICKS))
            floatCnt <= floatCnt + 12'h001;
      end
   end

   // Fan run-on timers, loaded on their event and counted down per tick
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         prevRun     <= 1'b0;
         prevHeat    <= 1'b0;
         prevCoolRec <= 1'b0;
         runOnLeft   <= 12'h000;
         coolFanLeft <= 12'h000;
         heatFanLeft <= 12'h000;
      end
      else
      begin
         prevRun     <= run;
         prevHeat    <= mode == iups_pkg::MODE_HEAT;
         prevCoolRec <= coolReq && idleUnit;
         if (run)
            runOnLeft <= 12'h000;
         else if (prevRun && prevHeat)
            runOnLeft <= 12'(iups_pkg::RUNON_TICKS);
         else if (tick && runOnLeft != 12'h000)
            runOnLeft <= runOnLeft - 12'h001;
         if (!(coolReq && idleUnit))
            coolFanLeft <= 12'h000;
         else if (!prevCoolRec && ctrl[iups_pkg::CTRL_FOURWAY])
            coolFanLeft <= 12'(iups_pkg::COOLREC_TICKS);
         else if (tick && coolFanLeft != 12'h000)
            coolFanLeft <= coolFanLeft - 12'h001;
         if (hr != iups_pkg::HR_IDLE && !heatReq && ctrl[iups_pkg::CTRL_FOURWAY])
            heatFanLeft <= 12'(iups_pkg::HEATREC_TICKS);
         else if (tick && heatFanLeft != 12'h000)
            heatFanLeft <= heatFanLeft - 12'h001;
      end
   end

   // ==========================================================
   // Heating recovery sequence
   // open, fan stop, close on temperature
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         hr <= iups_pkg::HR_IDLE;
      else
         unique case (hr)
            iups_pkg::HR_IDLE:
               if (heatReq && idleUnit)
                  hr <= iups_pkg::HR_OPEN;
            iups_pkg::HR_OPEN:
               if (!heatReq)
                  hr <= iups_pkg::HR_IDLE;
               else if (tc2 >= iups_pkg::HEATREC_CLOSE)
                  hr <= iups_pkg::HR_SHUT;
            iups_pkg::HR_SHUT:
               if (!heatReq)
                  hr <= iups_pkg::HR_IDLE;
            default:
               hr <= iups_pkg::HR_IDLE;
         endcase
   end

   // ==========================================================
   // Outputs
   logic [1:0] next_fanSpeed;
   logic       next_check;
   always_comb
   begin
      if (hr != iups_pkg::HR_IDLE)
         next_fanSpeed = iups_pkg::FAN_OFF;
      else if (frz == iups_pkg::FRZ_HELD)
         next_fanSpeed = iups_pkg::FAN_LOW;
      else if (run && !(thOffEff && mode == iups_pkg::MODE_HEAT))
         next_fanSpeed = iups_pkg::FAN_SET;
      else if (runOnLeft != 12'h000 || coolFanLeft != 12'h000 || heatFanLeft != 12'h000)
         next_fanSpeed = iups_pkg::FAN_LOW;
      else
         next_fanSpeed = iups_pkg::FAN_OFF;
   end

   // two minute float, set wins over clear
   assign next_check = (floatCnt == 12'(iups_pkg::FLOAT_TICKS)) || (checkCode && !clrCheck);

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         compressorRun     <= 1'b0;
         zeroFrequencyCode <= 1'b0;
         fanSpeed          <= iups_pkg::FAN_OFF;
         drainPump         <= 1'b0;
         expansionValve    <= 1'b0;
         warmupIndicator   <= 1'b0;
         louverRun         <= 1'b0;
         checkCode         <= 1'b0;
         outdoorStop       <= 1'b0;
         standbyIndicator  <= 1'b0;
      end
      else
      begin
         compressorRun     <= run && mode != iups_pkg::MODE_FAN && !thOffEff && !protect;
         zeroFrequencyCode <= frz == iups_pkg::FRZ_HELD;
         fanSpeed          <= next_fanSpeed;
         drainPump         <= coolActive || floatOn;
         expansionValve    <= (coolReq && idleUnit) || hr == iups_pkg::HR_OPEN;
         warmupIndicator   <= hr != iups_pkg::HR_IDLE && run
                              && (thOffEff || mode == iups_pkg::MODE_FAN);
         louverRun         <= ctrl[iups_pkg::CTRL_LOUVER] && next_fanSpeed != iups_pkg::FAN_OFF;
         checkCode         <= next_check;
         outdoorStop       <= next_check;
         standbyIndicator  <= next_check;
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   logic [3:0]  awAddr;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic        haveAw;
   logic        haveW;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         haveAw       <= 1'b0;
         haveW        <= 1'b0;
         awAddr       <= 4'h0;
         wData        <= 32'h00000000;
         wStrb        <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= iups_pkg::RESP_OKAY;
         ctrl         <= iups_pkg::CTRL_RESET;
         clrCheck     <= 1'b0;
      end
      else
      begin
         clrCheck <= 1'b0;
         if (s_axi_awvalid && s_axi_awready)
         begin
            haveAw <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            haveW <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (haveAw && haveW && !s_axi_bvalid)
         begin
            haveAw       <= 1'b0;
            haveW        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= iups_pkg::RESP_OKAY;
            if (awAddr == iups_pkg::ADDR_CTRL)
            begin
               if (wStrb[0])
                  ctrl <= wData[6:0];
               if (wStrb[1])
                  clrCheck <= wData[iups_pkg::CTRL_CLRCHK];
            end
            else if (awAddr != iups_pkg::ADDR_STATUS && awAddr != iups_pkg::ADDR_TEMPS
                     && awAddr != iups_pkg::ADDR_TIMERS)
               s_axi_bresp <= iups_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign s_axi_awready = !haveAw && !s_axi_bvalid;
   assign s_axi_wready  = !haveW && !s_axi_bvalid;

   // Read side answers one cycle after the address is taken
   logic [31:0] next_rdata;
   logic        next_rerr;
   always_comb
   begin
      next_rdata = 32'h00000000;
      next_rerr  = 1'b0;
      unique case (s_axi_araddr)
         iups_pkg::ADDR_CTRL:   next_rdata = {25'h0000000, ctrl};
         iups_pkg::ADDR_STATUS: next_rdata = {20'h00000, thOffEff, floatOn, fanSpeed,
                                              louverRun, checkCode, warmupIndicator,
                                              expansionValve, drainPump, compressorRun,
                                              zeroFrequencyCode, frz == iups_pkg::FRZ_HELD};
         iups_pkg::ADDR_TEMPS:  next_rdata = {16'h0000, tc2, tc1};
         iups_pkg::ADDR_TIMERS: next_rdata = {4'h0, floatCnt, 4'h0, freezeCnt};
         default:               next_rerr  = 1'b1;
      endcase
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= iups_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rerr ? iups_pkg::RESP_SLVERR : iups_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign s_axi_arready = !s_axi_rvalid;

endmodule

// file: hdl/iups_pkg.sv
/*
   Shared constants for the indoor unit protection sequencer: register map,
   field positions, reset values, temperature zones and second/minute times.
   Assumes a 250 MHz controller clock and a one second system tick.
*/
package iups_pkg;

   // ==========================================================
   // Clock and tick
   localparam int CLK_HZ          = 250_000_000;
   localparam int TICK_PERIOD_S   = 1;
   localparam int TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;

   // ==========================================================
   // Times, counted in ticks
   localparam int FREEZE_MIN      = 5;
   localparam int FREEZE_TICKS    = FREEZE_MIN * 60 / TICK_PERIOD_S;
   localparam int UNFREEZE_MIN    = 30;
   localparam int UNFREEZE_TICKS  = UNFREEZE_MIN * 60 / TICK_PERIOD_S;
   localparam int MINRUN_MIN      = 5;
   localparam int MINRUN_TICKS    = MINRUN_MIN * 60 / TICK_PERIOD_S;
   localparam int FLOAT_MIN       = 2;
   localparam int FLOAT_TICKS     = FLOAT_MIN * 60 / TICK_PERIOD_S;
   localparam int RUNON_SEC       = 30;
   localparam int RUNON_TICKS     = RUNON_SEC / TICK_PERIOD_S;
   localparam int COOLREC_FAN_SEC = 210;
   localparam int COOLREC_TICKS   = COOLREC_FAN_SEC / TICK_PERIOD_S;
   localparam int HEATREC_FAN_SEC = 60;
   localparam int HEATREC_TICKS   = HEATREC_FAN_SEC / TICK_PERIOD_S;

   // ==========================================================
   // Temperature zones, signed whole degrees C
   localparam logic signed [7:0] RELEASE_TEMP  = 8'sh0C;
   localparam logic signed [7:0] TIMING_TC1    = 8'sh00;
   localparam logic signed [7:0] TIMING_TC2    = -8'sh0F;
   localparam logic signed [7:0] HEATREC_CLOSE = 8'sh1E;

   // ==========================================================
   // Register map, byte addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_TEMPS  = 4'h8;
   localparam logic [3:0] ADDR_TIMERS = 4'hC;

   // Control fields
   localparam int CTRL_RUN      = 0;
   localparam int CTRL_MODE_LO  = 1;
   localparam int CTRL_FOURWAY  = 3;
   localparam int CTRL_THOFF    = 4;
   localparam int CTRL_SETPT    = 5;
   localparam int CTRL_LOUVER   = 6;
   localparam int CTRL_CLRCHK   = 8;
   localparam logic [6:0] CTRL_RESET = 7'h00;

   // Operating modes within the control word
   localparam logic [1:0] MODE_FAN  = 2'h0;
   localparam logic [1:0] MODE_COOL = 2'h1;
   localparam logic [1:0] MODE_HEAT = 2'h2;

   // Fan speed codes
   localparam logic [1:0] FAN_OFF = 2'h0;
   localparam logic [1:0] FAN_LOW = 2'h1;
   localparam logic [1:0] FAN_SET = 2'h2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {FRZ_NORMAL = 2'b01, FRZ_HELD = 2'b10} iups_frz_t;
   typedef enum logic [2:0] {HR_IDLE = 3'b001, HR_OPEN = 3'b010, HR_SHUT = 3'b100} iups_hr_t;

endpackage

// file: tb/iups_outdoor_model.sv
/* Outdoor unit side: recovery requests.
   Assumes bench wants change on mclk. */
`timescale 1ns/1ns
module iups_outdoor_model
(
   input  wire logic mclk,            // Clock
   input  wire logic reset,           // Async reset
   input  wire logic wantCool,        // Bench cool ask
   input  wire logic wantHeat,        // Bench heat ask
   input  wire logic outdoorStop,     // Stop order
   output logic      coolRecoveryReq, // Cool request
   output logic      heatRecoveryReq  // Heat request
);
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         {coolRecoveryReq, heatRecoveryReq} <= 2'h0;
      else
         {coolRecoveryReq, heatRecoveryReq} <= outdoorStop ? 2'h0 : {wantCool, wantHeat};
   end
endmodule

// file: tb/iups_seq_chk_sva.sv
/* Checks on sequencer pins.
   Assumes check code cleared only after float drops. */
`timescale 1ns/1ns
module iups_seq_chk
#(
   parameter int TICK_CYCLES = 4
)
(
   input wire logic       mclk,                // Clock
   input wire logic       reset,               // Reset
   input wire logic       s_axi_bvalid,        // B valid
   input wire logic       s_axi_bready,        // B ready
   input wire logic [7:0] coilTempFirst,       // Coil temp
   input wire logic [7:0] heatExchangerTemp,   // Exchanger temp
   input wire logic       overflowFloatSwitch, // Float
   input wire logic       compressorRun,       // Compressor
   input wire logic       zeroFrequencyCode,   // Zero freq
   input wire logic [1:0] fanSpeed,            // Fan
   input wire logic       drainPump,           // Drain
   input wire logic       louverRun,           // Louver
   input wire logic       checkCode,           // Check code
   input wire logic       outdoorStop,         // Outdoor stop
   input wire logic       standbyIndicator     // Standby
);
   // ==========
   // Float age; tick phase gives one tick slack
   localparam int LO = 119 * TICK_CYCLES;
   localparam int HI = 121 * TICK_CYCLES + 4;
   int fc;
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         fc <= 0;
      else
         fc <= overflowFloatSwitch ? fc + 1 : 0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   property p_chkEarly; $rose(checkCode) |-> fc >= LO; endproperty
   a_chkEarly: assert property (p_chkEarly) else $error("check code early");
   property p_chkLate; fc == HI |-> checkCode; endproperty
   a_chkLate: assert property (p_chkLate) else $error("check code late");
   property p_float; overflowFloatSwitch [*4] |-> !compressorRun && drainPump; endproperty
   a_float: assert property (p_float) else $error("float response");
   property p_rel; ($signed(coilTempFirst) >= 12 && $signed(heatExchangerTemp) >= 12) [*5]
      |-> !zeroFrequencyCode; endproperty
   a_rel: assert property (p_rel) else $error("freeze not released");
   property p_zfComp; zeroFrequencyCode |-> !compressorRun; endproperty
   a_zfComp: assert property (p_zfComp) else $error("compressor on at zero freq");
   property p_zfFan; zeroFrequencyCode |-> fanSpeed == iups_pkg::FAN_LOW; endproperty
   a_zfFan: assert property (p_zfFan) else $error("fan not low at zero freq");
   property p_stop; checkCode |-> outdoorStop && standbyIndicator; endproperty
   a_stop: assert property (p_stop) else $error("check code without stop");
   property p_louv; louverRun |-> fanSpeed != 2'h0 || $past(fanSpeed) != 2'h0; endproperty
   a_louv: assert property (p_louv) else $error("louver with fan off");
   property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bHold: assert property (p_bHold) else $error("bvalid dropped");
   cover property ($rose(zeroFrequencyCode));
   cover property ($rose(checkCode));
   cover property ($rose(louverRun));
endmodule
bind iups_sequencer iups_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.mclk(mclk),
   .reset(reset), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .coilTempFirst(coilTempFirst), .heatExchangerTemp(heatExchangerTemp),
   .overflowFloatSwitch(overflowFloatSwitch), .compressorRun(compressorRun),
   .zeroFrequencyCode(zeroFrequencyCode), .fanSpeed(fanSpeed), .drainPump(drainPump),
   .louverRun(louverRun), .checkCode(checkCode), .outdoorStop(outdoorStop),
   .standbyIndicator(standbyIndicator));

// file: tb/tb.sv
/* Sequencer bench over AXI4-Lite and pins.
   Assumes short tick of 4 clocks. */
`timescale 1ns/1ns
module tb;
   localparam int T = 4;
   logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, arvalid = 0, flt = 0, wC = 0, wH = 0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [7:0] tc1 = 8'h14, tc2 = 8'h14;
   logic awready, wready, bvalid, arready, rvalid, cR, hR;
   logic comp, zf, drain, valve, warm, louv, chk, oStop, stby;
   logic [1:0] bresp, rresp, fan;
   int failures = 0, checks = 0;
   always #2 mclk = ~mclk;
   iups_sequencer #(.TICK_CYCLES(T)) i_dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .coilTempFirst(tc1), .heatExchangerTemp(tc2), .overflowFloatSwitch(flt),
      .coolRecoveryReq(cR), .heatRecoveryReq(hR), .compressorRun(comp), .zeroFrequencyCode(zf),
      .fanSpeed(fan), .drainPump(drain), .expansionValve(valve), .warmupIndicator(warm),
      .louverRun(louv), .checkCode(chk), .outdoorStop(oStop), .standbyIndicator(stby));
   iups_outdoor_model i_odu (.mclk(mclk), .reset(reset), .wantCool(wC), .wantHeat(wH),
      .outdoorStop(oStop), .coolRecoveryReq(cR), .heatRecoveryReq(hR));
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tk(input int n);
      repeat (n * T) @(posedge mclk);
   endtask
   // Ready read mid-cycle, so the handshake edge is known
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic da = 0, dw = 0;
      @(posedge mclk);
      {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'h3, 2'h3};
      while (!(da && dw))
      begin
         @(negedge mclk);
         da = da || awready === 1'b1;
         dw = dw || wready === 1'b1;
         @(posedge mclk);
         awvalid <= awvalid && !da;
         wvalid <= wvalid && !dw;
      end
      do @(negedge mclk); while (bvalid !== 1'b1);
      cmp("bresp", 32'h0, bresp);
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      {araddr, arvalid} <= {a, 1'b1};
      do @(negedge mclk); while (arready !== 1'b1);
      @(posedge mclk);
      arvalid <= 1'b0;
      do @(negedge mclk); while (rvalid !== 1'b1);
      d = rdata;
      cmp("rresp", 32'h0, rresp);
      @(posedge mclk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      failures++;
      report_and_stop;
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rd(iups_pkg::ADDR_CTRL, q);
      cmp("ctrl", 32'h0, q);
      rd(iups_pkg::ADDR_TEMPS, q);
      cmp("temps", 32'h1414, q & 32'hFFFF);
      wr(iups_pkg::ADDR_CTRL, 32'h3);
      tc1 <= 8'hFF;
      tk(200);
      tc1 <= 8'h05;
      tk(200);
      tc1 <= 8'hFF;
      tk(95);
      cmp("zf", 32'h0, zf);
      tk(10);
      cmp("zf", 32'h1, zf);
      cmp("fan", iups_pkg::FAN_LOW, fan);
      {tc1, tc2} <= 16'h0C0C;
      tk(2);
      cmp("zf", 32'h0, zf);
      rd(iups_pkg::ADDR_TIMERS, q);
      cmp("frzcnt", 32'h0, q & 32'hFFF);
      $display("test freeze done");
      {tc1, tc2, flt} <= {16'h1414, 1'b1};
      tk(2);
      cmp("drain", 32'h1, drain & !comp);
      tk(113);
      cmp("chk", 32'h0, chk);
      tk(10);
      cmp("chk", 32'h7, {chk, oStop, stby});
      flt <= 1'b0;
      wr(iups_pkg::ADDR_CTRL, 32'h103);
      tk(1);
      cmp("chk", 32'h3, {chk, comp, drain});
      wr(iups_pkg::ADDR_CTRL, 32'h1);
      tk(1);
      cmp("drain", 32'h0, drain);
      $display("test drain done");
      wr(iups_pkg::ADDR_CTRL, 32'h0);
      wr(iups_pkg::ADDR_CTRL, 32'h13);
      tk(10);
      cmp("comp", 32'h1, comp);
      wr(iups_pkg::ADDR_CTRL, 32'h33);
      tk(1);
      cmp("comp", 32'h0, comp);
      wr(iups_pkg::ADDR_CTRL, 32'h13);
      tk(300);
      cmp("comp", 32'h0, comp);
      $display("test minrun done");
      tc2 <= 8'h28;
      wr(iups_pkg::ADDR_CTRL, 32'h5);
      wr(iups_pkg::ADDR_CTRL, 32'h0);
      tk(2);
      cmp("fan", iups_pkg::FAN_LOW, fan);
      tk(33);
      cmp("fan", iups_pkg::FAN_OFF, fan);
      wr(iups_pkg::ADDR_CTRL, 32'h43);
      tk(2);
      cmp("louv", 32'h1, louv);
      wr(iups_pkg::ADDR_CTRL, 32'h40);
      tk(2);
      cmp("louv", 32'h0, louv);
      $display("test fan done");
      wr(iups_pkg::ADDR_CTRL, 32'h8);
      wC <= 1'b1;
      tk(2);
      cmp("valve", {31'h0, 1'b1}, valve);
      cmp("fan", iups_pkg::FAN_LOW, fan);
      tk(213);
      cmp("fan", iups_pkg::FAN_OFF, fan);
      tc2 <= 8'h14;
      wr(iups_pkg::ADDR_CTRL, 32'h9);
      {wC, wH} <= 2'h1;
      tk(2);
      cmp("valve", 32'h7, {valve, fan == iups_pkg::FAN_OFF, warm});
      tc2 <= 8'h23;
      tk(2);
      cmp("valve", 32'h0, valve);
      wH <= 1'b0;
      wr(iups_pkg::ADDR_CTRL, 32'h8);
      tk(2);
      cmp("fan", iups_pkg::FAN_LOW, fan);
      tk(62);
      cmp("fan", iups_pkg::FAN_OFF, fan);
      $display("test recovery done");
      report_and_stop;
   end
endmodule
